// *** rtl/rxca_aligner.sv ***
// receive comma detection, byte alignment, manual slip and bypass
// assumes raw_word is the deserialised word on mclk, and that user
// fabric logic and the register master also run on mclk
`include "rxca_regs.svh"
module rxca_aligner
    import rxca_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [`RXCA_ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire rxca_word_t raw_word,
    input wire logic comma_block_use,
    input wire logic minus_align_enable,
    input wire logic plus_align_enable,
    input wire logic bit_slip_request,
    output rxca_word_t rx_parallel_word,
    output logic comma_seen_flag,
    output logic byte_aligned_flag,
    output logic realign_pulse
);
    logic [8:0] ctrl;
    rxca_byte_t pattern_mask;
    rxca_byte_t minus_pattern;
    rxca_byte_t plus_pattern;
    rxca_word_t prev_word;
    rxca_word_t cur_word;
    rxca_word_t lag_word0;
    rxca_word_t lag_word1;
    rxca_ptr_t ptr;
    logic slip_q;
    logic slip_rise_q;
    logic [2*`RXCA_WORD_W-1:0] window;
    logic [`RXCA_OFFSETS-1:0] minus_hit;
    logic [`RXCA_OFFSETS-1:0] plus_hit;
    logic [`RXCA_OFFSETS-1:0] any_hit;
    rxca_ptr_t first_idx;
    logic hit_found;
    logic is_plus;
    logic is_minus;
    logic sets_ok;
    logic align_ok;
    logic legal;
    logic even_mode;
    logic two_byte;
    logic slip_rise;
    logic slip_now;
    rxca_ptr_t next_ptr;
    rxca_ptr_t target;
    rxca_word_t shifted;

    function automatic rxca_ptr_t mod_byte(input rxca_ptr_t v);
        mod_byte = (v >= `RXCA_BYTE_SPAN) ? v - `RXCA_BYTE_SPAN : v;
    endfunction

    assign two_byte = ctrl[`RXCA_CTRL_TWO_BYTE];
    // one-byte interface always runs as any boundary
    assign even_mode = two_byte &&
        (ctrl[`RXCA_CTRL_BND_HI:`RXCA_CTRL_BND_LO] == RXCA_BND_EVEN);

    // register port
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= `RXCA_RST_CTRL;
            pattern_mask <= `RXCA_RST_MASK;
            minus_pattern <= `RXCA_RST_MINUS;
            plus_pattern <= `RXCA_RST_PLUS;
        end else if (ce && wr_en) begin
            case (addr)
                `RXCA_OFS_CTRL: ctrl <= wr_data[8:0];
                `RXCA_OFS_MASK: pattern_mask <= wr_data[9:0];
                `RXCA_OFS_MINUS: minus_pattern <= wr_data[9:0];
                `RXCA_OFS_PLUS: plus_pattern <= wr_data[9:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data <= 32'h0;
        end else if (ce) begin
            rd_data <= 32'h0;
            if (rd_en) begin
                case (addr)
                    `RXCA_OFS_CTRL: rd_data <= {23'h0, ctrl};
                    `RXCA_OFS_MASK: rd_data <= {22'h0, pattern_mask};
                    `RXCA_OFS_MINUS: rd_data <= {22'h0, minus_pattern};
                    `RXCA_OFS_PLUS: rd_data <= {22'h0, plus_pattern};
                    `RXCA_OFS_STATUS: begin
                        rd_data <= {19'h0, ptr, 6'h0,
                            comma_seen_flag, byte_aligned_flag};
                    end
                    default: rd_data <= 32'h0;
                endcase
            end
        end
    end

    // two-word search window, older word in the low half
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_word <= '0;
            cur_word <= '0;
        end else if (ce) begin
            prev_word <= cur_word;
            cur_word <= raw_word;
        end
    end

    assign window = {cur_word, prev_word};

    rxca_comma_match u_match (
        .window(window),
        .pattern_mask(pattern_mask),
        .minus_pattern(minus_pattern),
        .plus_pattern(plus_pattern),
        .paired(ctrl[`RXCA_CTRL_PAIRED]),
        .minus_hit(minus_hit),
        .plus_hit(plus_hit)
    );

    assign any_hit = minus_hit | plus_hit;

    // lowest offset carrying any comma
    always_comb begin
        first_idx = '0;
        hit_found = 1'b0;
        for (int i = `RXCA_OFFSETS - 1; i >= 0; i--) begin
            if (any_hit[i]) begin
                first_idx = rxca_ptr_t'(i);
                hit_found = 1'b1;
            end
        end
    end

    always_comb begin
        is_plus = plus_hit[first_idx];
        is_minus = minus_hit[first_idx];
        sets_ok = (is_plus && ctrl[`RXCA_CTRL_PSET]) ||
            (is_minus && ctrl[`RXCA_CTRL_MSET]);
        align_ok = (is_plus && plus_align_enable) ||
            (is_minus && minus_align_enable);
        // legal spot: exact pointer for even, same byte phase otherwise
        if (even_mode) begin
            legal = first_idx == ptr;
            target = first_idx;
        end else begin
            legal = mod_byte(first_idx) == mod_byte(ptr);
            target = mod_byte(first_idx);
        end
    end

    // slip request edge; spacing is kept by the user logic
    assign slip_rise = bit_slip_request && !slip_q;
    // analog stage slips at once, coding stage one cycle later
    assign slip_now = ctrl[`RXCA_CTRL_SLIP_PMA] ? slip_rise : slip_rise_q;
    assign next_ptr = (ptr == `RXCA_PTR_MAX) ? '0 : ptr + 5'h01;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            slip_q <= 1'b0;
            slip_rise_q <= 1'b0;
        end else if (ce) begin
            slip_q <= bit_slip_request;
            slip_rise_q <= slip_rise;
        end
    end

    // alignment pointer, aligned flag and realign pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ptr <= '0;
            byte_aligned_flag <= 1'b0;
            realign_pulse <= 1'b0;
        end else if (ce) begin
            realign_pulse <= 1'b0;
            if (!comma_block_use) begin
                byte_aligned_flag <= 1'b0;
            end else if (slip_now) begin
                ptr <= next_ptr;
                byte_aligned_flag <= 1'b0;
            end else if (hit_found) begin
                if (legal) begin
                    if (sets_ok) begin
                        byte_aligned_flag <= 1'b1;
                    end
                end else begin
                    byte_aligned_flag <= 1'b0;
                    if (align_ok) begin
                        ptr <= target;
                        realign_pulse <= 1'b1;
                    end
                end
            end
        end
    end

    // comma seen flag ahead of the aligned data
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            comma_seen_flag <= 1'b0;
        end else if (ce) begin
            comma_seen_flag <= comma_block_use && (
                ((|minus_hit) && ctrl[`RXCA_CTRL_MDET]) ||
                ((|plus_hit) && ctrl[`RXCA_CTRL_PDET]));
        end
    end

    assign shifted = window[ptr +: `RXCA_WORD_W];

    // aligned data, two stages behind the seen flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lag_word0 <= '0;
            lag_word1 <= '0;
            rx_parallel_word <= '0;
        end else if (ce) begin
            lag_word0 <= shifted;
            lag_word1 <= lag_word0;
            if (!comma_block_use) begin
                rx_parallel_word <= cur_word;
            end else if (two_byte) begin
                rx_parallel_word <= lag_word1;
            end else begin
                rx_parallel_word <= {10'h000, lag_word1[9:0]};
            end
        end
    end

    property p_realign_single;
        @(posedge mclk) disable iff (rst)
        (realign_pulse && ce) |=> !realign_pulse;
    endproperty
    a_realign_single: assert property (p_realign_single)
        else $error("realign pulse longer than one cycle");

    property p_realign_drops_aligned;
        @(posedge mclk) disable iff (rst)
        realign_pulse |-> !byte_aligned_flag;
    endproperty
    a_realign_drops_aligned: assert property (p_realign_drops_aligned)
        else $error("aligned flag high during realignment");

    property p_bypass_quiet;
        @(posedge mclk) disable iff (rst)
        (ce && !comma_block_use) |=>
            !comma_seen_flag && !byte_aligned_flag && !realign_pulse;
    endproperty
    a_bypass_quiet: assert property (p_bypass_quiet)
        else $error("status active while block bypassed");

    property p_detect_gate;
        @(posedge mclk) disable iff (rst)
        (ce && !ctrl[`RXCA_CTRL_MDET] && !ctrl[`RXCA_CTRL_PDET]) |=>
            !comma_seen_flag;
    endproperty
    a_detect_gate: assert property (p_detect_gate)
        else $error("seen flag raised with both detect enables off");

    property p_slip_step;
        @(posedge mclk) disable iff (rst)
        (ce && comma_block_use && slip_now) |=>
            ptr == (($past(ptr) == `RXCA_PTR_MAX) ? 5'h00 : $past(ptr) + 5'h01);
    endproperty
    a_slip_step: assert property (p_slip_step)
        else $error("slip did not move pointer by one bit");

    property p_even_target;
        @(posedge mclk) disable iff (rst)
        (realign_pulse && $past(even_mode)) |-> ptr == $past(first_idx);
    endproperty
    a_even_target: assert property (p_even_target)
        else $error("even boundary realign to wrong offset");

    property p_any_target;
        @(posedge mclk) disable iff (rst)
        (realign_pulse && !$past(even_mode)) |-> ptr < `RXCA_BYTE_SPAN;
    endproperty
    a_any_target: assert property (p_any_target)
        else $error("any boundary realign beyond first byte");

    property p_rise_cause;
        @(posedge mclk) disable iff (rst)
        $rose(byte_aligned_flag) |-> $past(sets_ok) && $past(legal);
    endproperty
    a_rise_cause: assert property (p_rise_cause)
        else $error("aligned flag rose without enabled comma");

    property p_freeze;
        @(posedge mclk) disable iff (rst)
        (ce && !minus_align_enable && !plus_align_enable && !slip_now) |=>
            ptr == $past(ptr) && !realign_pulse;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("pointer moved with alignment disabled");

    c_realign: cover property (@(posedge mclk) disable iff (rst)
        realign_pulse);
    c_aligned: cover property (@(posedge mclk) disable iff (rst)
        $rose(byte_aligned_flag));
    c_slip: cover property (@(posedge mclk) disable iff (rst)
        ce && comma_block_use && slip_now);
endmodule

// *** rtl/rxca_comma_match.sv ***
// masked plus, minus and paired comma compare at every bit offset
// assumes a 40-bit window, older word low, bit 0 received first
`include "rxca_regs.svh"
module rxca_comma_match
    import rxca_pkg::*;
(
    input wire logic [2*`RXCA_WORD_W-1:0] window,
    input wire rxca_byte_t pattern_mask,
    input wire rxca_byte_t minus_pattern,
    input wire rxca_byte_t plus_pattern,
    input wire logic paired,
    output logic [`RXCA_OFFSETS-1:0] minus_hit,
    output logic [`RXCA_OFFSETS-1:0] plus_hit
);
    genvar g;
    generate
        for (g = 0; g < `RXCA_OFFSETS; g = g + 1) begin : g_ofs
            logic [`RXCA_BYTE_W-1:0] first_b;
            logic [`RXCA_BYTE_W-1:0] second_b;
            logic p_eq;
            logic m_eq;
            logic m_next;
            assign first_b = window[g +: `RXCA_BYTE_W];
            assign second_b = window[g + `RXCA_BYTE_W +: `RXCA_BYTE_W];
            // cleared mask bits are don't-care
            assign p_eq = ((first_b ^ plus_pattern) & pattern_mask) == '0;
            assign m_eq = ((first_b ^ minus_pattern) & pattern_mask) == '0;
            assign m_next = ((second_b ^ minus_pattern) & pattern_mask) == '0;
            // paired mode: plus then minus back to back
            assign plus_hit[g] = paired ? (p_eq & m_next) : p_eq;
            assign minus_hit[g] = paired ? (p_eq & m_next) : m_eq;
        end
    endgenerate
endmodule

// *** rtl/rxca_pkg.sv ***
// types shared by the comma detect and byte align block
// assumes rxca_regs.svh sits on the include path
package rxca_pkg;
`include "rxca_regs.svh"

    typedef logic [`RXCA_WORD_W-1:0] rxca_word_t;
    typedef logic [`RXCA_BYTE_W-1:0] rxca_byte_t;
    typedef logic [`RXCA_PTR_W-1:0] rxca_ptr_t;

    typedef enum logic [1:0] {
        RXCA_BND_ANY = 2'h1,
        RXCA_BND_EVEN = 2'h2
    } rxca_bnd_t;
endpackage

// *** rtl/rxca_regs.svh ***
// register offsets, control fields, reset values and fixed sizes of the
// comma detect and byte align block; included by the package and the rtl
`ifndef RXCA_REGS_SVH
`define RXCA_REGS_SVH

// register word indices on the plain register port
`define RXCA_ADDR_W 3
`define RXCA_OFS_CTRL 3'h0
`define RXCA_OFS_MASK 3'h1
`define RXCA_OFS_MINUS 3'h2
`define RXCA_OFS_PLUS 3'h3
`define RXCA_OFS_STATUS 3'h4

// control register fields
`define RXCA_CTRL_BND_LO 0
`define RXCA_CTRL_BND_HI 1
`define RXCA_CTRL_PAIRED 2
`define RXCA_CTRL_MDET 3
`define RXCA_CTRL_PDET 4
`define RXCA_CTRL_MSET 5
`define RXCA_CTRL_PSET 6
`define RXCA_CTRL_SLIP_PMA 7
`define RXCA_CTRL_TWO_BYTE 8

// status register fields
`define RXCA_STAT_ALIGNED 0
`define RXCA_STAT_SEEN 1
`define RXCA_STAT_PTR_LO 8
`define RXCA_STAT_PTR_HI 12

// reset values
`define RXCA_RST_CTRL 9'h17B
`define RXCA_RST_MASK 10'h3FF
`define RXCA_RST_MINUS 10'h283
`define RXCA_RST_PLUS 10'h17C

// datapath sizes
`define RXCA_BYTE_W 10
`define RXCA_WORD_W 20
`define RXCA_OFFSETS 20
`define RXCA_PTR_W 5
`define RXCA_PTR_MAX 5'h13
`define RXCA_BYTE_SPAN 5'h0A

`endif

// *** test/rxca_aligner_test.sv ***
// self-checking bench for the comma detect and byte align block
// assumes the fabric model supplies stream and controls on mclk
`include "rxca_regs.svh"
module rxca_aligner_test
    import rxca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [`RXCA_ADDR_W-1:0] addr = '0;
    logic [31:0] wr_data = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data;
    rxca_word_t raw_word;
    rxca_word_t rx_parallel_word;
    logic comma_block_use, minus_align_enable, plus_align_enable;
    logic bit_slip_request, comma_seen_flag, byte_aligned_flag;
    logic realign_pulse;
    int n_errors = 0;
    int n_compared = 0;
    int n_pulse = 0;

    always #2 mclk = ~mclk;
    // pulses counted mid-cycle, away from the launching edge
    always @(negedge mclk) if (realign_pulse === 1'b1) n_pulse++;

    rxca_aligner u_dut (
        .mclk, .rst, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .raw_word, .comma_block_use, .minus_align_enable,
        .plus_align_enable, .bit_slip_request, .rx_parallel_word,
        .comma_seen_flag, .byte_aligned_flag, .realign_pulse
    );
    rxca_fabric_model u_fab (
        .mclk, .raw_word, .comma_block_use, .minus_align_enable,
        .plus_align_enable, .bit_slip_request
    );

    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, e);
    endtask

    task automatic status(input int ptr, input logic sn, al);
        rchk(`RXCA_OFS_STATUS, {19'h0, 5'(ptr), 6'h0, sn, al});
    endtask

    task automatic wait_al();
        int i;
        for (i = 0; i < 64; i++) begin
            @(posedge mclk);
            #1;
            if (byte_aligned_flag === 1'b1)
                break;
        end
        if (i == 64) begin
            n_errors++;
            $display("[FAIL] %0t aligned flag never rose", $time);
            results();
        end
    endtask

    // freeze, move the stream, configure, then let the block align
    task automatic align(input logic [19:0] b, input int s,
        input logic m, p, input logic [8:0] c, input int ptr,
        input logic al, sn, input int np);
        int c0;
        u_fab.enables(1'b1, 1'b0, 1'b0);
        u_fab.stream(b, s);
        wr(`RXCA_OFS_CTRL, {23'h0, c});
        repeat (4) @(posedge mclk);
        c0 = n_pulse;
        u_fab.enables(1'b1, m, p);
        if (al)
            wait_al();
        else
            repeat (8) @(posedge mclk);
        repeat (6) @(posedge mclk);
        #1;
        chk(n_pulse - c0, np);
        status(ptr, sn, al);
        chk(rx_parallel_word, u_fab.rotl(u_fab.rotl(b, s), 20 - ptr));
        $display("case done at %0t", $time);
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        wr(3'h5, 32'h3FF);
        rchk(`RXCA_OFS_CTRL, 32'(`RXCA_RST_CTRL));
        rchk(`RXCA_OFS_MASK, 32'h3FF);
        rchk(`RXCA_OFS_MINUS, 32'h283);
        rchk(`RXCA_OFS_PLUS, 32'h17C);
        rchk(`RXCA_OFS_STATUS, 32'h0);
        rchk(3'h5, 32'h0);
        $display("reset values done");
        align(20'h55683, 13, 1, 0, 9'h129, 3, 1, 1, 1);
        align(20'h55683, 13, 1, 0, 9'h12A, 13, 1, 1, 1);
        align(20'h55683, 5, 0, 0, 9'h122, 13, 0, 0, 0);
        align(20'h55683, 5, 1, 0, 9'h102, 5, 0, 0, 1);
        align(20'h5557C, 7, 0, 1, 9'h151, 7, 1, 1, 1);
        wr(`RXCA_OFS_MASK, 32'h3FE);
        wr(`RXCA_OFS_MINUS, 32'h282);
        align(20'h55683, 2, 1, 0, 9'h129, 2, 1, 1, 1);
        align(20'h55683, 6, 1, 1, 9'h17D, 2, 1, 0, 0);
        align(20'hA0D7C, 6, 1, 1, 9'h17D, 6, 1, 1, 1);
        u_fab.enables(1'b1, 1'b0, 1'b0);
        u_fab.slip();
        u_fab.slip();
        repeat (6) @(posedge mclk);
        #1;
        status(8, 1'b1, 1'b0);
        chk(rx_parallel_word, u_fab.rotl(20'hA0D7C, 18));
        wr(`RXCA_OFS_CTRL, 32'h1FD);
        u_fab.slip();
        repeat (6) @(posedge mclk);
        status(9, 1'b1, 1'b0);
        wr(`RXCA_OFS_CTRL, 32'h0FD);
        repeat (6) @(posedge mclk);
        #1;
        chk(rx_parallel_word, u_fab.rotl(20'hA0D7C, 17) & 20'h003FF);
        $display("one byte done");
        u_fab.enables(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge mclk);
        #1;
        chk(rx_parallel_word, u_fab.rotl(20'hA0D7C, 6));
        status(9, 1'b0, 1'b0);
        @(posedge mclk);
        ce <= 1'b0;
        wr(`RXCA_OFS_MASK, 32'h001);
        ce <= 1'b1;
        rchk(`RXCA_OFS_MASK, 32'h3FE);
        $display("slip and bypass done");
        results();
    end
endmodule

// *** test/rxca_fabric_model.sv ***
// user fabric stand-in: comma stream, align enables and slip
// assumes one clock shared with the aligner; bench calls its tasks
module rxca_fabric_model
    import rxca_pkg::*;
(
    input wire logic mclk,
    output rxca_word_t raw_word,
    output logic comma_block_use,
    output logic minus_align_enable,
    output logic plus_align_enable,
    output logic bit_slip_request
);
    timeunit 1ns;
    timeprecision 1ps;
    rxca_word_t base = 20'h55683;
    int phase = 13;

    function automatic rxca_word_t rotl(rxca_word_t w, int n);
        return (w << n) | (w >> (20 - n));
    endfunction

    // one word per period, comma at bit offset phase
    assign raw_word = rotl(base, phase);

    initial begin
        comma_block_use = 1'b0;
        minus_align_enable = 1'b0;
        plus_align_enable = 1'b0;
        bit_slip_request = 1'b0;
    end

    task automatic stream(input rxca_word_t b, input int s);
        @(posedge mclk);
        base <= b;
        phase <= s;
    endtask

    task automatic enables(input logic u, m, p);
        @(posedge mclk);
        comma_block_use <= u;
        minus_align_enable <= m;
        plus_align_enable <= p;
    endtask

    task automatic slip();
        @(posedge mclk);
        bit_slip_request <= 1'b1;
        @(posedge mclk);
        bit_slip_request <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
endmodule
